// ==== core/smpm_pkg.sv ====
// package: register map, field layout and types for the page-mode timing block
package smpm_pkg;
  localparam int unsigned NUM_CS         = 8;
  localparam int unsigned CS_W           = 3;
  localparam int unsigned ADDR_W         = 26;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  SLOT_BYTES     = 8'h10;
  localparam logic [3:0]  OFF_SETUP      = 4'h0;
  localparam logic [3:0]  OFF_PULSE      = 4'h4;
  localparam logic [3:0]  OFF_CYCLE      = 4'h8;
  localparam logic [3:0]  OFF_MODE       = 4'hc;
  localparam logic [31:0] RST_SETUP      = 32'h00000000;
  localparam logic [31:0] RST_PULSE      = 32'h01010101;
  localparam logic [31:0] RST_CYCLE      = 32'h00010001;
  localparam logic [31:0] RST_MODE       = 32'h10001000;
  // writable bits; reserved bits read as zero
  localparam logic [31:0] MSK_SETUP      = 32'h3f3f3f3f;
  localparam logic [31:0] MSK_PULSE      = 32'h7f7f7f7f;
  localparam logic [31:0] MSK_CYCLE      = 32'h01ff01ff;
  localparam logic [31:0] MSK_MODE       = 32'h331f3133;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned F_RD_STB_PULSE = 16;
  localparam int unsigned F_CS_RD_PULSE  = 24;
  localparam int unsigned F_BYTE_ACCESS  = 8;
  localparam int unsigned F_BUS_WIDTH    = 12;
  localparam int unsigned F_PAGE_EN      = 24;
  localparam int unsigned F_PAGE_SIZE    = 28;
  localparam int unsigned F_EXT_WAIT     = 4;
  localparam int unsigned SETUP_HI_BIT   = 5;
  localparam int unsigned PULSE_HI_BIT   = 6;
  localparam logic [8:0]  SETUP_HI_WT    = 9'h080;
  localparam logic [8:0]  PULSE_HI_WT    = 9'h100;
  localparam logic [1:0]  DBW_16         = 2'h1;
  localparam logic [1:0]  DBW_32         = 2'h2;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [CS_W-1:0]   cs;
    logic [ADDR_W-1:0] addr;
  } smpm_req_t;

  typedef struct packed {
    logic       page_en;
    logic [1:0] page_size;
    logic [1:0] bus_width;
    logic       byte_access;
    logic [1:0] ext_wait;
  } smpm_mode_t;

  typedef enum logic [3:0] {
    SMPM_IDLE  = 4'h1,
    SMPM_SETUP = 4'h2,
    SMPM_PULSE = 4'h4,
    SMPM_HOLD  = 4'h8
  } smpm_state_t;
endpackage

// ==== core/smpm_len_decode.sv ====
// decoder: turns a packed setup or pulse field into a cycle count
`timescale 1ns/1ps
module smpm_len_decode import smpm_pkg::*; #(
  parameter int unsigned HI_BIT = 5          // weighted high bit position
) (
  input  wire logic [HI_BIT:0] field,        // packed field value
  output logic      [8:0]      cycles        // decoded length in cycles
);
  localparam logic [8:0] HI_WT = (HI_BIT == SETUP_HI_BIT) ? SETUP_HI_WT
                                                           : PULSE_HI_WT;
  always_comb begin
    cycles = (field[HI_BIT] ? HI_WT : 9'h000)
           + 9'(field[HI_BIT-1:0]);
  end
endmodule

// ==== core/smpm_core.sv ====
// page-mode read timing core with per-chip-select register file over apb
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module smpm_core import smpm_pkg::*; (
  input  wire logic              pclk,            // apb and memory clock
  input  wire logic              presetn,         // async reset, low
  input  wire logic              psel,            // apb select
  input  wire logic              penable,         // apb access phase
  input  wire logic              pwrite,          // apb direction
  input  wire logic [7:0]        paddr,           // apb byte address
  input  wire logic [31:0]       pwdata,          // apb write data
  output logic      [31:0]       prdata,          // apb read data
  output logic                   pready,          // apb ready
  output logic                   pslverr,         // apb error
  input  wire smpm_req_t         req,             // memory access request
  output logic                   req_ready,       // request taken
  output logic                   done,            // access finished pulse
  output logic                   config_done,     // mode write pulse
  output logic                   page_hit,        // last access was an in-page page read
  output logic [NUM_CS-1:0]      chip_select_n,   // chip selects
  output logic                   read_strobe_n,   // read strobe
  output logic                   write_strobe_n,  // write strobe
  output logic [ADDR_W-1:0]      mem_addr,        // memory address
  output logic                   byte_select_mode // byte select lanes
);
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] setup_r [NUM_CS];
  logic [31:0] pulse_r [NUM_CS];
  logic [31:0] cycle_r [NUM_CS];
  logic [31:0] mode_r  [NUM_CS];

  logic            acc;
  logic            mapped;
  logic [CS_W-1:0] rcs;
  logic [3:0]      roff;

  assign rcs     = paddr[CS_W+3:4];
  assign roff    = paddr[3:0];
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0);
  assign acc     = psel && penable;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CS; i++) begin
        setup_r[i] <= RST_SETUP;
        pulse_r[i] <= RST_PULSE;
        cycle_r[i] <= RST_CYCLE;
        mode_r[i]  <= RST_MODE;
      end
    end else if (acc && pwrite && mapped) begin
      case (roff)
        OFF_SETUP: setup_r[rcs] <= pwdata & MSK_SETUP;
        OFF_PULSE: pulse_r[rcs] <= pwdata & MSK_PULSE;
        OFF_CYCLE: cycle_r[rcs] <= pwdata & MSK_CYCLE;
        OFF_MODE:  mode_r[rcs]  <= pwdata & MSK_MODE;
        default: begin
        end
      endcase
    end
  end

  // mode write marks configuration complete
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_done <= 1'b0;
    end else begin
      config_done <= acc && pwrite && mapped && roff == OFF_MODE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr[3:0])
        OFF_SETUP: prdata <= setup_r[paddr[CS_W+3:4]];
        OFF_PULSE: prdata <= pulse_r[paddr[CS_W+3:4]];
        OFF_CYCLE: prdata <= cycle_r[paddr[CS_W+3:4]];
        OFF_MODE:  prdata <= mode_r[paddr[CS_W+3:4]];
        default:   prdata <= 32'h00000000;
      endcase
      if (paddr[7]) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // decode timing of the addressed chip select
  // ----------------------------------------------------------------
  smpm_req_t   cur;
  smpm_mode_t  md;
  logic [31:0] cs_setup;
  logic [31:0] cs_pulse;
  logic [31:0] cs_mode;
  logic [8:0]  len_rs;
  logic [8:0]  len_cs_rs;
  logic [8:0]  len_ws;
  logic [8:0]  len_cs_ws;
  logic [8:0]  len_rp;
  logic [8:0]  len_cs_rp;
  logic [8:0]  len_wp;
  logic [8:0]  len_cs_wp;

  assign cs_setup = setup_r[cur.cs];
  assign cs_pulse = pulse_r[cur.cs];
  assign cs_mode  = mode_r[cur.cs];

  always_comb begin
    md             = '0;
    md.page_en     = cs_mode[F_PAGE_EN];
    md.page_size   = cs_mode[F_PAGE_SIZE+:2];
    md.bus_width   = cs_mode[F_BUS_WIDTH+:2];
    md.byte_access = cs_mode[F_BYTE_ACCESS];
    md.ext_wait    = cs_mode[F_EXT_WAIT+:2];
  end

  smpm_len_decode #(.HI_BIT(SETUP_HI_BIT)) u_ws (
    .field(cs_setup[5:0]), .cycles(len_ws));
  smpm_len_decode #(.HI_BIT(SETUP_HI_BIT)) u_cws (
    .field(cs_setup[13:8]), .cycles(len_cs_ws));
  smpm_len_decode #(.HI_BIT(SETUP_HI_BIT)) u_rs (
    .field(cs_setup[21:16]), .cycles(len_rs));
  smpm_len_decode #(.HI_BIT(SETUP_HI_BIT)) u_crs (
    .field(cs_setup[29:24]), .cycles(len_cs_rs));
  smpm_len_decode #(.HI_BIT(PULSE_HI_BIT)) u_wp (
    .field(cs_pulse[6:0]), .cycles(len_wp));
  smpm_len_decode #(.HI_BIT(PULSE_HI_BIT)) u_cwp (
    .field(cs_pulse[14:8]), .cycles(len_cs_wp));
  smpm_len_decode #(.HI_BIT(PULSE_HI_BIT)) u_rp (
    .field(cs_pulse[F_RD_STB_PULSE+:7]), .cycles(len_rp));
  smpm_len_decode #(.HI_BIT(PULSE_HI_BIT)) u_crp (
    .field(cs_pulse[F_CS_RD_PULSE+:7]), .cycles(len_cs_rp));

  // ----------------------------------------------------------------
  // page tracking
  // ----------------------------------------------------------------
  logic              pg_valid;
  logic [CS_W-1:0]   pg_cs;
  logic [ADDR_W-1:0] pg_addr;
  logic [ADDR_W-1:0] page_mask;
  logic [ADDR_W-1:0] ign_mask;
  logic              in_page;

  always_comb begin
    case (md.page_size)
      2'h0:    page_mask = ~ADDR_W'(32'h3);
      2'h1:    page_mask = ~ADDR_W'(32'h7);
      2'h2:    page_mask = ~ADDR_W'(32'hf);
      default: page_mask = ~ADDR_W'(32'h1f);
    endcase
    // low bits under the bus width never select a word
    case (md.bus_width)
      DBW_16:  ign_mask = ~ADDR_W'(32'h1);
      DBW_32:  ign_mask = ~ADDR_W'(32'h3);
      default: ign_mask = ~ADDR_W'(32'h0);
    endcase
  end

  assign in_page = pg_valid && pg_cs == cur.cs
                && ((pg_addr ^ cur.addr) & page_mask & ign_mask)
                   == ADDR_W'(32'h0);

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  smpm_state_t st;
  smpm_state_t next_st;
  logic [9:0]  tcyc;
  logic [9:0]  next_tcyc;
  logic        page_rd;
  logic [9:0]  page_len;
  logic [9:0]  sel_on;
  logic [9:0]  sel_off;
  logic [9:0]  stb_on;
  logic [9:0]  stb_off;
  logic [9:0]  acc_end;
  logic [9:0]  w_sel_on;
  logic [9:0]  w_sel_off;
  logic [9:0]  w_stb_on;
  logic [9:0]  w_stb_off;

  assign page_rd   = !cur.write && md.page_en;
  assign page_len  = 10'(in_page ? len_rp : len_cs_rp);
  assign req_ready = (st == SMPM_IDLE);
  assign byte_select_mode = !md.byte_access;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else if (req_ready && req.valid) begin
      cur <= req;
    end
  end

  // low windows of select and strobe, counted from the pulse start
  always_comb begin
    if (page_rd) begin
      // page reads skip setup whatever is programmed
      w_sel_on  = 10'h000;
      w_sel_off = page_len;
      w_stb_on  = 10'h000;
      w_stb_off = page_len;
    end else if (cur.write) begin
      w_sel_on  = 10'(len_cs_ws);
      w_sel_off = 10'(len_cs_ws) + 10'(len_cs_wp);
      w_stb_on  = 10'(len_ws);
      w_stb_off = 10'(len_ws) + 10'(len_wp);
    end else begin
      w_sel_on  = 10'(len_cs_rs);
      w_sel_off = 10'(len_cs_rs) + 10'(len_cs_rp);
      w_stb_on  = 10'(len_rs);
      w_stb_off = 10'(len_rs) + 10'(len_rp);
    end
  end

  // windows freeze at the start of an access, so a register write
  // during a transfer only takes effect on the next one, except on byte_select_mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_on  <= 10'h000;
      sel_off <= 10'h000;
      stb_on  <= 10'h000;
      stb_off <= 10'h000;
      acc_end <= 10'h000;
    end else if (st == SMPM_SETUP) begin
      sel_on  <= w_sel_on;
      sel_off <= w_sel_off;
      stb_on  <= w_stb_on;
      stb_off <= w_stb_off;
      acc_end <= (w_sel_off > w_stb_off) ? w_sel_off : w_stb_off;
    end
  end

  always_comb begin
    next_st   = st;
    next_tcyc = tcyc;
    case (st)
      SMPM_IDLE: begin
        if (req.valid) begin
          next_st   = SMPM_SETUP;
          next_tcyc = 10'h000;
        end
      end
      SMPM_SETUP: begin
        next_st   = SMPM_PULSE;
        next_tcyc = 10'h000;
      end
      SMPM_PULSE: begin
        // a zero length still spends one cycle here, so a bad
        // program cannot stall the sequencer
        if (tcyc + 10'h001 >= acc_end) begin
          next_st = SMPM_HOLD;
        end else begin
          next_tcyc = tcyc + 10'h001;
        end
      end
      SMPM_HOLD: begin
        next_st = SMPM_IDLE;
      end
      default: begin
        next_st = SMPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st   <= SMPM_IDLE;
      tcyc <= 10'h000;
    end else begin
      st   <= next_st;
      tcyc <= next_tcyc;
    end
  end

  // page record is taken in the setup cycle of each access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_valid <= 1'b0;
      pg_cs    <= '0;
      pg_addr  <= '0;
      page_hit <= 1'b0;
    end else if (st == SMPM_SETUP) begin
      page_hit <= page_rd && in_page;
      // any non-page access drops select, so breaks the page
      pg_valid <= page_rd;
      pg_cs    <= cur.cs;
      pg_addr  <= cur.addr;
    end
  end

  // ----------------------------------------------------------------
  // memory pins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_select_n  <= '1;
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
      mem_addr       <= '0;
      done           <= 1'b0;
    end else begin
      done <= (st == SMPM_HOLD);
      mem_addr <= cur.addr;
      chip_select_n <= '1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      if (st == SMPM_PULSE && tcyc >= sel_on && tcyc < sel_off) begin
        chip_select_n[cur.cs] <= 1'b0;
        // strobe is clipped to the select window, so the device
        // is always selected while it is strobed
        if (tcyc >= stb_on && tcyc < stb_off) begin
          read_strobe_n  <= cur.write;
          write_strobe_n <= !cur.write;
        end
      end
    end
  end
endmodule

// ==== verif/smpm_core_chk.sv ====
// checker: port-level properties of the page-mode timing core
`timescale 1ns/1ps
module smpm_core_chk import smpm_pkg::*; (
  input wire logic              pclk,           // clock
  input wire logic              presetn,        // async reset, low
  input wire logic              psel,           // apb select
  input wire logic              penable,        // apb access
  input wire logic              pwrite,         // apb direction
  input wire logic [7:0]        paddr,          // apb address
  input wire logic [31:0]       prdata,         // apb read data
  input wire logic              pslverr,        // apb error
  input wire logic              done,           // access end pulse
  input wire logic              config_done,    // mode write pulse
  input wire logic              page_hit,       // in-page flag
  input wire logic [NUM_CS-1:0] chip_select_n,  // selects
  input wire logic              read_strobe_n,  // read strobe
  input wire logic              write_strobe_n  // write strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mode_wr;
  assign acc = psel && penable;
  assign mode_wr = acc && pwrite && paddr < 8'h80 && paddr[3:0] == OFF_MODE;
  strobe_sel_a: assert property (!read_strobe_n |-> !(&chip_select_n))
    else $error("read strobe low with no select");
  one_sel_a: assert property ($onehot0(~chip_select_n))
    else $error("more than one select low");
  rd_wr_a: assert property (!read_strobe_n |-> write_strobe_n)
    else $error("read and write strobes low together");
  wr_sel_a: assert property (!write_strobe_n |-> !(&chip_select_n))
    else $error("write strobe low with no select");
  bad_addr_a: assert property (acc && paddr >= 8'h80 |-> pslverr)
    else $error("unmapped access not refused");
  good_addr_a: assert property (
    acc && paddr < 8'h80 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  bad_rd_a: assert property (
    acc && !pwrite && paddr >= 8'h80 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  cfg_done_a: assert property (config_done == $past(mode_wr))
    else $error("config pulse not tied to mode write");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  done_rel_a: assert property (done |-> &chip_select_n)
    else $error("select still low at done");
  reset_idle_a: assert property (
    $rose(presetn) |-> &chip_select_n && !done && !page_hit)
    else $error("not idle after reset");
  hit_c: cover property ($rose(page_hit));
  cfg_c: cover property (config_done);
  err_c: cover property (acc && pslverr);
  wr_c: cover property (!write_strobe_n);
endmodule

bind smpm_core smpm_core_chk u_chk (.*);

// ==== verif/smpm_mem_model.sv ====
// model: page memory side, measures how long select and strobe stay low
`timescale 1ns/1ps
module smpm_mem_model import smpm_pkg::*; (
  input wire logic              pclk,           // clock
  input wire logic [NUM_CS-1:0] chip_select_n,  // selects
  input wire logic              read_strobe_n,  // read strobe
  output int                    last_len,       // last select low time
  output int                    last_rlen       // last strobe low time
);
  int cnt = 0;
  int rcnt = 0;
  initial last_len = 0;
  initial last_rlen = 0;
  // lengths latch when the select returns high, one access per pulse
  always @(posedge pclk) begin
    if (!(&chip_select_n)) begin
      cnt <= cnt + 1;
      rcnt <= rcnt + (read_strobe_n ? 0 : 1);
    end else begin
      if (cnt != 0) last_len <= cnt;
      if (cnt != 0) last_rlen <= rcnt;
      cnt <= 0;
      rcnt <= 0;
    end
  end
endmodule

// ==== verif/smpm_core_tb.sv ====
// testbench: register map and page-mode read timing of the core
`timescale 1ns/1ps
module smpm_core_tb import smpm_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, req_ready, done, config_done, page_hit;
  logic read_strobe_n, write_strobe_n, byte_select_mode, wr_req = 1'b0;
  logic [NUM_CS-1:0] chip_select_n;
  logic [ADDR_W-1:0] mem_addr, b;
  smpm_req_t req = '0;
  int err_total = 0, cmp_count = 0, mlen, rlen;
  initial forever #12.5 pclk = ~pclk;
  smpm_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .req_ready(req_ready), .done(done), .config_done(config_done),
    .page_hit(page_hit), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .mem_addr(mem_addr), .byte_select_mode(byte_select_mode));
  smpm_mem_model mem (.pclk(pclk), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .last_len(mlen), .last_rlen(rlen));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    $display("BAD %0t wait ran out", $time);
    finish_test();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) tmo();
  endtask
  task automatic rdx(input logic [2:0] c, input logic [25:0] a,
                     input int n, input logic h, input logic pm);
    int k;
    @(posedge pclk);
    req <= '{1'b1, wr_req, c, a};
    k = 0;
    do begin @(posedge pclk); k++; end while (req_ready !== 1'b1 && k < 20);
    req.valid <= 1'b0;
    do begin @(posedge pclk); k++; end while (done !== 1'b1 && k < 400);
    if (done !== 1'b1) tmo();
    repeat (2) @(posedge pclk);
    chk(mlen, n);
    chk({31'h0, page_hit}, {31'h0, h});
    chk({6'h0, mem_addr}, {6'h0, a});
    if (pm) chk(rlen, n);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, RST_SETUP);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, RST_PULSE);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, RST_CYCLE);
    apb(1'b0, 8'h7c, 32'h0);
    chk(rd, RST_MODE);
    apb(1'b1, 8'h10, 32'hffffffff);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, MSK_SETUP);
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'h00, 32'h05050505);
    apb(1'b1, 8'h04, 32'h05020101);
    apb(1'b1, 8'h0c, 32'h11000000);
    @(posedge pclk);
    chk({31'h0, byte_select_mode}, 32'h1);
    rdx(3'h0, 26'h1, 5, 1'b0, 1'b1);
    rdx(3'h0, 26'h7, 2, 1'b1, 1'b1);
    rdx(3'h0, 26'h3, 2, 1'b1, 1'b1);
    rdx(3'h1, 26'h5, 1, 1'b0, 1'b0);
    rdx(3'h0, 26'h5, 5, 1'b0, 1'b1);
    b = 26'h0;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h0c, {2'h0, c[1:0], 4'h1, 24'h0});
      b = b + 26'h1000;
      rdx(3'h0, b, 5, 1'b0, 1'b1);
      rdx(3'h0, b + (26'h4 << c) - 26'h1, 2, 1'b1, 1'b1);
      rdx(3'h0, b + (26'h4 << c), 5, 1'b0, 1'b1);
    end
    apb(1'b1, 8'h04, 32'h01030101);
    apb(1'b1, 8'h0c, 32'h11000100);
    @(posedge pclk);
    chk({31'h0, byte_select_mode}, 32'h0);
    rdx(3'h0, 26'h40, 1, 1'b0, 1'b1);
    rdx(3'h0, 26'h41, 3, 1'b1, 1'b1);
    apb(1'b1, 8'h04, 32'h41020101);
    rdx(3'h0, 26'h80, 257, 1'b0, 1'b1);
    apb(1'b1, 8'h0c, 32'h00000000);
    rdx(3'h0, 26'h81, 257, 1'b0, 1'b0);
    wr_req = 1'b1;
    rdx(3'h0, 26'h82, 1, 1'b0, 1'b0);
    finish_test();
  end
endmodule
